// *** bench/dcrs_ctrl_tb_top.sv ***
// Self-checking bench for the diagnostic reset controller
module dcrs_ctrl_tb_top
	import dcrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [33:0] e;
		logic [33:0] m;
	} dcrs_exp_s;

	logic        aclk, aresetn, awready, wready, bvalid, arready, rvalid;
	logic        awvalid, wvalid, bready, arvalid, rready, diag_lock;
	logic        demand, heat_dmd, cool_dmd;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed, r;
	logic [3:0]  wstrb, diag_cond, diag_act;
	logic [1:0]  bresp, rresp;
	dcrs_sw_s    sw;
	dcrs_out_s   unit;
	dcrs_exp_s   rq[$], uq[$], ex;
	int          n_errors, checks, n;
	logic [7:0]  md [6] = '{8'h01, 8'h21, 8'h31, 8'h11, 8'h11, 8'h00};
	logic [5:0]  dm     = 6'b001000;
	logic [4:0]  ue [6] = '{5'h10, 5'h10, 5'h10, 5'h18, 5'h00, 5'h00};
	logic [4:0]  um [6] = '{5'h10, 5'h10, 5'h10, 5'h18, 5'h18, 5'h1e};
	logic [4:0]  te [7] = '{5'h00, 5'h01, 5'h19, 5'h05, 5'h03, 5'h01,
		5'h11};

	dcrs_ctrl #(.TICK_CYC(10), .HOLD_SEC(4), .LOCK_SEC(20)) dut_u (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.awaddr    (awaddr),
		.awvalid   (awvalid),
		.awready   (awready),
		.wdata     (wdata),
		.wstrb     (wstrb),
		.wvalid    (wvalid),
		.wready    (wready),
		.bresp     (bresp),
		.bvalid    (bvalid),
		.bready    (bready),
		.araddr    (araddr),
		.arvalid   (arvalid),
		.arready   (arready),
		.rdata     (rdata),
		.rresp     (rresp),
		.rvalid    (rvalid),
		.rready    (rready),
		.sw        (sw),
		.diag_cond (diag_cond),
		.demand    (demand),
		.heat_dmd  (heat_dmd),
		.cool_dmd  (cool_dmd),
		.unit      (unit),
		.diag_act  (diag_act),
		.diag_lock (diag_lock)
	);

	dcrs_field_model fm_u (
		.aclk      (aclk),
		.sw        (sw),
		.diag_cond (diag_cond),
		.demand    (demand),
		.heat_dmd  (heat_dmd),
		.cool_dmd  (cool_dmd)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic stop_test();
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta) begin
				awvalid <= 1'b0;
				da = 1'b1;
			end
			if (tw) begin
				wvalid <= 1'b0;
				dw = 1'b1;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		input logic [33:0] m);
		rq.push_back('{e & m, m});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(A_STATUS, {2'b00, e}, {2'b11, m});
	endtask

	task automatic lu(input logic [4:0] e, input logic [4:0] m);
		uq.push_back('{34'(e & m), 34'(m)});
	endtask

	task automatic pwr(input logic [15:0] w);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		if (w != 16'h0)
			wr(A_WAIT, {16'h0, w}, 4'hf);
	endtask

	task automatic up(input int lo, input int hi);
		n = 0;
		while (unit.unit_on !== 1'b1 && n < 400) begin
			@(negedge aclk);
			n++;
		end
		chk(34'(n >= lo && n <= hi), 34'h1);
	endtask

	// ==========================================================
	// Result monitor
	always @(negedge aclk) begin
		if (rvalid && rready) begin
			ex = rq.pop_front();
			chk({rresp, rdata} & ex.m, ex.e);
		end
		if (uq.size() > 0) begin
			ex = uq.pop_front();
			chk(34'(unit) & ex.m, ex.e);
		end
	end

	initial begin
		repeat (10000) @(posedge aclk);
		n_errors++;
		stop_test();
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 32'd96443;
		n_errors = 0;
		checks = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		pwr(16'h0);
		up(40, 320);
		rd(A_MODE, 34'h1, 34'h3_0000_00ff);
		rd(A_WAIT, 34'h0, 34'h3_0000_ffff);
		rd(8'h14, 34'h2_0000_0000, '1);
		fm_u.cause(4'h2);
		pwr(16'hffff);
		repeat (400) @(posedge aclk);
		st(32'h0002_0400, 32'h00ff_4600);
		fm_u.cause(4'h0);
		wr(A_NETREQ, 32'h1, 4'hf);
		st(32'h0000_0600, 32'h00ff_0600);
		pwr(16'h3);
		up(50, 340);
		for (int i = 0; i < 6; i++) begin
			fm_u.load(dm[i], 1'b1, 1'b1);
			wr(A_MODE, {24'h0, md[i]}, 4'hf);
			repeat (3) @(posedge aclk);
			lu(ue[i], um[i]);
		end
		wr(A_MODE, 32'h11, 4'hf);
		for (int i = 0; i < 6; i++) begin
			r = xs();
			fm_u.load(r[0], r[1], r[2]);
			repeat (3) @(posedge aclk);
			lu({r[0], r[0], r[2], r[1], 1'b1}, 5'h1f);
		end
		wr(A_MODE, 32'h1, 4'hf);
		fm_u.fan(1'b1, 2'h0);
		lu(5'h00, 5'h11);
		fm_u.pulse(4'h2);
		fm_u.pulse(4'h1);
		st(32'h0003_0003, 32'h00ff_01ff);
		rd(A_ORDER, 34'h12, 34'h3_0000_ffff);
		repeat (50) @(posedge aclk);
		st(32'h0002_0002, 32'h00ff_01ff);
		fm_u.pulse(4'h1);
		repeat (60) @(posedge aclk);
		st(32'h0003_0103, 32'h00ff_01ff);
		fm_u.cause(4'h6);
		wr(A_NETREQ, 32'h1, 4'he);
		st(32'h0003_0107, 32'h00ff_01ff);
		wr(A_NETREQ, 32'h2, 4'hf);
		st(32'h0003_0107, 32'h00ff_01ff);
		wr(A_NETREQ, 32'h1, 4'hf);
		st(32'h0002_0006, 32'h00ff_01ff);
		fm_u.cause(4'h0);
		st(32'h0002_0002, 32'h00ff_01ff);
		fm_u.fan(1'b1, 2'h2);
		st(32'h0000_0000, 32'h00ff_01ff);
		fm_u.pulse(4'h2);
		for (int i = 1; i < 7; i++) begin
			if (i == 5)
				fm_u.pulse(4'h2);
			fm_u.press();
			st(32'((i % 6) << 11), (i == 1 || i == 5) ? 32'h00ff_3800
				: 32'h0000_3800);
			lu(te[i], (i == 6) ? 5'h11 : 5'h1f);
		end
		fm_u.cause(4'h1);
		repeat (50) @(posedge aclk);
		st(32'h0001_0101, 32'h00ff_01ff);
		repeat (3) @(posedge aclk);
		stop_test();
	end
endmodule

// *** bench/dcrs_field_model.sv ***
// Local switches and sensor causes around the controller
module dcrs_field_model
	import dcrs_pkg::*;
(
	input  wire logic  aclk,
	output dcrs_sw_s   sw,
	output logic [3:0] diag_cond,
	output logic       demand,
	output logic       heat_dmd,
	output logic       cool_dmd
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sw = '0;
		diag_cond = '0;
		demand = 1'b0;
		heat_dmd = 1'b1;
		cool_dmd = 1'b1;
	end

	// ==========================================================
	// Operator actions
	task automatic press();
		@(posedge aclk);
		sw.test_btn <= 1'b1;
		repeat (2) @(posedge aclk);
		sw.test_btn <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic fan(input logic l, input logic [1:0] v);
		@(posedge aclk);
		sw.sw_local <= l;
		sw.fan_sw <= v;
		repeat (3) @(posedge aclk);
	endtask

	// ==========================================================
	// Plant conditions
	task automatic cause(input logic [3:0] v);
		@(posedge aclk);
		diag_cond <= v;
		repeat (2) @(posedge aclk);
	endtask

	task automatic pulse(input logic [3:0] v);
		@(posedge aclk);
		diag_cond <= v;
		@(posedge aclk);
		diag_cond <= 4'h0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic load(input logic d, input logic h, input logic c);
		@(posedge aclk);
		demand <= d;
		heat_dmd <= h;
		cool_dmd <= c;
	endtask
endmodule

// *** logic/dcrs_ctrl.sv ***
// Diagnostic clearing, coil fault auto recovery and start-up gating
//
// Implementation choices: the address map and the AXI4-Lite register port.
module dcrs_ctrl
	import dcrs_pkg::*;
#(
	parameter int                N_DIAG     = 4,
	parameter logic [N_DIAG-1:0] LATCH_MASK = N_DIAG'(3),
	parameter int                TICK_CYC   = dcrs_pkg::TICK_CYC,
	parameter int                HOLD_SEC   = HOLD_S,
	parameter int                LOCK_SEC   = LOCK_S
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [7:0]    awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [7:0]    araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	input  wire dcrs_sw_s      sw,
	input  wire logic [N_DIAG-1:0] diag_cond,
	input  wire logic          demand,
	input  wire logic          heat_dmd,
	input  wire logic          cool_dmd,
	output dcrs_out_s          unit,
	output logic [N_DIAG-1:0]  diag_act,
	output logic               diag_lock
);

	localparam logic [SEC_W-1:0] HOLD_LAST = SEC_W'(HOLD_SEC - 1);
	localparam logic [SEC_W-1:0] LOCK_LAST = SEC_W'(LOCK_SEC - 1);
	localparam logic [N_DIAG-1:0] OTHER = ~N_DIAG'(1);

	if (N_DIAG < 2 || N_DIAG > 8 || !LATCH_MASK[0] || HOLD_SEC < 1 ||
		LOCK_SEC < 1 || LOCK_SEC >= 2 ** SEC_W ||
		HOLD_SEC >= 2 ** SEC_W) begin : g_chk
		$error("unsupported parameter values");
	end

	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic                   aw_got;
		logic                   w_got;
		logic [7:0]             awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic [1:0]             op;
		logic [1:0]             occ;
		logic [15:0]            wait_s;
		dcrs_phase_e            phase;
		dcrs_test_e             test;
		logic                   btn_d;
		logic [1:0]             sw_d;
		logic [15:0]            lfsr;
		logic [4:0]             rnd_s;
		logic [15:0]            ph_sec;
		logic [N_DIAG-1:0]      lat;
		logic [N_DIAG-1:0]      act;
		logic                   lock;
		logic                   win;
		logic [SEC_W-1:0]       lc_sec;
		logic [SEC_W-1:0]       win_sec;
		logic [N_DIAG-1:0][3:0] stamp;
		logic [3:0]             cnt;
		dcrs_out_s              out;
	} dcrs_st_s;

	dcrs_st_s          s;
	dcrs_st_s          next_s;
	logic              tick;
	logic              clr;
	logic              net_clr;
	logic              tst_clr;
	logic              sw_clr;
	logic              comm;
	logic              press;
	logic              auto_fire;
	logic              off;
	logic              run_ok;
	logic [N_DIAG-1:0] set;
	logic [4:0]        rv;
	logic [31:0]       rd;
	dcrs_out_s         o;

	dcrs_tick #(
		.CYC (TICK_CYC)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	always_comb begin
		next_s = s;
		net_clr = 1'b0;
		tst_clr = 1'b0;
		comm = 1'b0;
		rd = '0;
		o = '0;
		// ==========================================================
		// Register bus slave
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		if (awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = awaddr;
			next_s.awready = 1'b0;
		end
		if (wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
			next_s.wready = 1'b0;
		end
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.awaddr)
				A_NETREQ: begin
					comm = 1'b1;
					net_clr = s.wstrb[0] &&
						(s.wdata[7:0] == NET_CLEAR_ALARM);
				end
				A_MODE: begin
					comm = 1'b1;
					if (s.wstrb[0]) begin
						next_s.op = s.wdata[MODE_OP_LSB +: 2];
						next_s.occ = s.wdata[MODE_OCC_LSB +: 2];
					end
				end
				A_WAIT: begin
					if (s.wstrb[0]) next_s.wait_s[7:0] = s.wdata[7:0];
					if (s.wstrb[1]) next_s.wait_s[15:8] = s.wdata[15:8];
				end
				A_STATUS, A_ORDER: ;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		case (araddr)
			A_MODE: begin
				rd[MODE_OP_LSB +: 2] = s.op;
				rd[MODE_OCC_LSB +: 2] = s.occ;
			end
			A_WAIT: rd[15:0] = s.wait_s;
			A_STATUS: begin
				rd[ST_ACT_LSB +: N_DIAG] = s.act;
				rd[ST_LOCK] = s.lock;
				rd[ST_PH_LSB +: 2] = s.phase;
				rd[ST_TEST_LSB +: 3] = s.test;
				rd[ST_UNIT] = s.out.unit_on;
				rd[ST_LAT_LSB +: N_DIAG] = s.lat;
			end
			A_ORDER: rd[4*N_DIAG-1:0] = s.stamp;
			default: rd = '0;
		endcase
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		if (arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rd;
			next_s.rresp = (araddr == A_NETREQ || araddr == A_MODE ||
				araddr == A_WAIT || araddr == A_STATUS ||
				araddr == A_ORDER) ? RESP_OKAY : RESP_SLVERR;
		end
		// ==========================================================
		// Manual output test and fan switch
		press = sw.test_btn && !s.btn_d;
		next_s.btn_d = sw.test_btn;
		if (press) begin
			case (s.test)
				TS_IDLE: begin
					next_s.test = TS_START;
					tst_clr = 1'b1;
				end
				TS_START: next_s.test = TS_FAN;
				TS_FAN: next_s.test = TS_VALVE;
				TS_VALVE: next_s.test = TS_HEAT;
				TS_HEAT: begin
					next_s.test = TS_END;
					tst_clr = 1'b1;
				end
				TS_END: next_s.test = TS_IDLE;
				default: next_s.test = TS_IDLE;
			endcase
		end
		next_s.sw_d = sw.fan_sw;
		sw_clr = (s.sw_d == FAN_OFF) && (sw.fan_sw != FAN_OFF);
		// ==========================================================
		// Start-up phases
		next_s.lfsr = {s.lfsr[14:0],
			s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10] ^ demand};
		rv = s.lfsr[4:0];
		if (rv >= RND_SPAN_V) rv = rv - RND_SPAN_V;
		case (s.phase)
			PH_CLEAR: begin
				next_s.phase = PH_RAND;
				next_s.rnd_s = rv + RND_MIN_V;
				next_s.ph_sec = '0;
			end
			PH_RAND: begin
				if (tick) begin
					if (s.ph_sec == 16'(s.rnd_s) - 16'h0001) begin
						next_s.phase = PH_WAIT;
						next_s.ph_sec = '0;
					end else begin
						next_s.ph_sec = s.ph_sec + 16'h0001;
					end
				end
			end
			PH_WAIT: begin
				if (s.wait_s == '0 || comm) begin
					next_s.phase = PH_RUN;
				end else if (tick) begin
					if (s.ph_sec == s.wait_s - 16'h0001) begin
						next_s.phase = PH_RUN;
					end else begin
						next_s.ph_sec = s.ph_sec + 16'h0001;
					end
				end
			end
			PH_RUN: ;
			default: next_s.phase = PH_CLEAR;
		endcase
		// ==========================================================
		// Diagnostic records
		clr = net_clr || tst_clr || sw_clr ||
			(s.phase == PH_CLEAR);
		auto_fire = tick && s.lat[0] && !s.lock && !clr &&
			(s.lc_sec == HOLD_LAST);
		set = diag_cond & LATCH_MASK;
		if (!s.lat[0]) begin
			next_s.lc_sec = '0;
		end else if (tick && !s.lock) begin
			next_s.lc_sec = s.lc_sec + 1'b1;
		end
		if (s.win && tick) begin
			if (s.win_sec == LOCK_LAST) next_s.win = 1'b0;
			else next_s.win_sec = s.win_sec + 1'b1;
		end
		if (auto_fire) begin
			next_s.lat[0] = 1'b0;
			next_s.lc_sec = '0;
			next_s.win = 1'b1;
			next_s.win_sec = '0;
		end
		if (clr) begin
			next_s.lat = '0;
			next_s.lock = 1'b0;
			next_s.win = 1'b0;
			next_s.lc_sec = '0;
		end
		if (set[0] && (auto_fire || (next_s.win && !s.lat[0]))) begin
			next_s.lock = 1'b1;
		end
		next_s.lat = next_s.lat | set;
		next_s.act = next_s.lat | (diag_cond & ~LATCH_MASK);
		if (next_s.act == '0) next_s.cnt = '0;
		for (int i = 0; i < N_DIAG; i++) begin
			if (!next_s.act[i]) begin
				next_s.stamp[i] = '0;
			end else if (!s.act[i]) begin
				next_s.cnt = next_s.cnt + 4'h1;
				next_s.stamp[i] = next_s.cnt;
			end
		end
		// ==========================================================
		// Unit outputs
		off = (sw.sw_local && sw.fan_sw == FAN_OFF) ||
			(s.op == OP_OFF) || (s.lat != '0);
		run_ok = (s.phase == PH_RUN) && !off && (s.test == TS_IDLE);
		if (s.test != TS_IDLE) begin
			o.unit_on = 1'b1;
			o.fan_on = (s.test == TS_FAN);
			o.fan_high = (s.test == TS_FAN);
			o.cool_valve = (s.test == TS_VALVE);
			o.heat = (s.test == TS_HEAT);
		end else if (run_ok) begin
			o.unit_on = 1'b1;
			if (s.occ == OCC_UNOCC) begin
				o.fan_on = demand;
				o.fan_high = demand;
			end else begin
				o.fan_on = 1'b1;
				o.fan_high = demand;
			end
			o.cool_valve = cool_dmd && (s.op != OP_HEAT);
			o.heat = heat_dmd && (s.op != OP_COOL);
		end
		next_s.out = o;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.op <= OP_AUTO;
			s.lfsr <= LFSR_SEED;
			s.phase <= PH_CLEAR;
			s.test <= TS_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign unit = s.out;
	assign diag_act = s.act;
	assign diag_lock = s.lock;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_auto_clr;
		auto_fire && !diag_cond[0] |=> !s.lat[0] && !s.lock && s.win;
	endproperty
	a_auto_clr: assert property (p_auto_clr)
		else $error("coil fault not auto cleared");

	property p_lock;
		s.lock && s.lat[0] && !clr |=> s.lock && s.lat[0];
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked coil fault cleared without reset");

	property p_recur;
		auto_fire && diag_cond[0] |=> s.lock && s.lat[0];
	endproperty
	a_recur: assert property (p_recur)
		else $error("recurrence did not lock out");

	property p_other;
		!clr |=> (($past(s.lat) & OTHER & ~s.lat) == '0);
	endproperty
	a_other: assert property (p_other)
		else $error("other fault cleared with no reset");

	property p_test;
		press && s.test == TS_HEAT |=>
			s.test == TS_END && s.lat == $past(set);
	endproperty
	a_test: assert property (p_test)
		else $error("last test step did not clear");

	property p_pwr;
		s.phase == PH_CLEAR |=> s.lat == $past(set) && !s.lock;
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("power-up did not clear");

	property p_net;
		net_clr |=> s.lat == $past(set) && !s.lock;
	endproperty
	a_net: assert property (p_net)
		else $error("network clear ignored");

	property p_fan_sw;
		sw_clr |=> s.lat == $past(set);
	endproperty
	a_fan_sw: assert property (p_fan_sw)
		else $error("fan switch clear ignored");

	property p_rand;
		s.phase != PH_RUN && s.test == TS_IDLE |=> !s.out.unit_on;
	endproperty
	a_rand: assert property (p_rand)
		else $error("unit on before start-up done");

	property p_rnd_rng;
		s.phase == PH_RAND |-> s.rnd_s >= RND_MIN_V &&
			s.rnd_s <= 5'(RND_MAX_S);
	endproperty
	a_rnd_rng: assert property (p_rnd_rng)
		else $error("random delay out of range");

	property p_wait;
		s.phase == PH_WAIT && comm |=> s.phase == PH_RUN;
	endproperty
	a_wait: assert property (p_wait)
		else $error("communication did not end control wait");

	property p_sw_off;
		sw.sw_local && sw.fan_sw == FAN_OFF && s.test == TS_IDLE
			|=> !s.out.unit_on;
	endproperty
	a_sw_off: assert property (p_sw_off)
		else $error("fan switch off did not stop unit");

	property p_mode_off;
		s.op == OP_OFF && s.test == TS_IDLE |=>
			!(s.out.fan_on || s.out.heat || s.out.cool_valve);
	endproperty
	a_mode_off: assert property (p_mode_off)
		else $error("mode off still drives outputs");

	property p_occ;
		run_ok && s.occ != OCC_UNOCC |=> s.out.fan_on;
	endproperty
	a_occ: assert property (p_occ)
		else $error("fan not continuous when occupied");

	property p_unocc;
		run_ok && s.occ == OCC_UNOCC |=>
			s.out.fan_on == $past(demand) &&
			s.out.fan_high == $past(demand);
	endproperty
	a_unocc: assert property (p_unocc)
		else $error("unoccupied fan does not follow demand");

	property p_nonlatch;
		1'b1 |=> (s.act & ~LATCH_MASK) == $past(diag_cond & ~LATCH_MASK);
	endproperty
	a_nonlatch: assert property (p_nonlatch)
		else $error("non-latching fault does not follow cause");

	c_auto: cover property (auto_fire);
	c_lock: cover property (s.lock && net_clr);
	c_test: cover property (s.test == TS_END);
	c_wait: cover property (s.phase == PH_WAIT && comm);

endmodule

// *** logic/dcrs_pkg.sv ***
// Constants and carrier types for the diagnostic reset controller
package dcrs_pkg;

	// ==========================================================
	// Time base
	localparam int CLK_HZ    = 100_000_000;
	localparam int TICK_S    = 1;
	localparam int TICK_CYC  = CLK_HZ * TICK_S;
	localparam int HOLD_MIN  = 30;
	localparam int HOLD_S    = HOLD_MIN * 60 / TICK_S;
	localparam int LOCK_H    = 24;
	localparam int LOCK_S    = LOCK_H * 3600 / TICK_S;
	localparam int RND_MIN_S = 5;
	localparam int RND_MAX_S = 30;
	localparam int SEC_W     = 17;
	localparam logic [4:0] RND_MIN_V  = 5'(RND_MIN_S);
	localparam logic [4:0] RND_SPAN_V = 5'(RND_MAX_S - RND_MIN_S + 1);
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] A_NETREQ = 8'h00;
	localparam logic [7:0] A_MODE   = 8'h04;
	localparam logic [7:0] A_WAIT   = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_ORDER  = 8'h10;

	// Field positions
	localparam int MODE_OP_LSB  = 0;
	localparam int MODE_OCC_LSB = 4;
	localparam int ST_ACT_LSB   = 0;
	localparam int ST_LOCK      = 8;
	localparam int ST_PH_LSB    = 9;
	localparam int ST_TEST_LSB  = 11;
	localparam int ST_UNIT      = 14;
	localparam int ST_LAT_LSB   = 16;

	// Encodings and reset values
	localparam logic [7:0] NET_CLEAR_ALARM = 8'h01;
	localparam logic [1:0] OP_OFF    = 2'h0;
	localparam logic [1:0] OP_AUTO   = 2'h1;
	localparam logic [1:0] OP_HEAT   = 2'h2;
	localparam logic [1:0] OP_COOL   = 2'h3;
	localparam logic [1:0] OCC_OCC   = 2'h0;
	localparam logic [1:0] OCC_UNOCC = 2'h1;
	localparam logic [1:0] FAN_OFF   = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {PH_CLEAR, PH_RAND, PH_WAIT, PH_RUN}
		dcrs_phase_e;
	typedef enum logic [2:0] {
		TS_IDLE, TS_START, TS_FAN, TS_VALVE, TS_HEAT, TS_END
	} dcrs_test_e;

	typedef struct packed {
		logic       sw_local;
		logic [1:0] fan_sw;
		logic       test_btn;
	} dcrs_sw_s;

	typedef struct packed {
		logic fan_on;
		logic fan_high;
		logic cool_valve;
		logic heat;
		logic unit_on;
	} dcrs_out_s;

endpackage

// *** logic/dcrs_tick.sv ***
// One-cycle pulse every CYC clock cycles, the slow time base
module dcrs_tick
	import dcrs_pkg::*;
#(
	parameter int CYC = TICK_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      tick
);

	localparam int CW = $clog2(CYC);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} dcrs_tk_s;

	dcrs_tk_s s;
	dcrs_tk_s next_s;

	if (CYC < 2) begin : g_chk
		$error("tick period must be at least two cycles");
	end

	always_comb begin
		next_s = s;
		next_s.tick = (s.cnt == LAST);
		next_s.cnt = (s.cnt == LAST) ? '0 : s.cnt + 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule
